// file: include/lps_pkg.sv
// Package of constants and types for the root port link power-state control
package lps_pkg;
    // ----------------------------------------
    // Device power states
    // ----------------------------------------
    typedef enum logic [2:0] {
        LPS_D0     = 3'h0,
        LPS_D1     = 3'h1,
        LPS_D2     = 3'h2,
        LPS_D3HOT  = 3'h3,
        LPS_D3COLD = 3'h4
    } lps_dstate_t;

    // ----------------------------------------
    // Link power states
    // ----------------------------------------
    typedef enum logic [2:0] {
        LPS_L0     = 3'h0,
        LPS_L1     = 3'h1,
        LPS_L23RDY = 3'h2,
        LPS_L2     = 3'h3,
        LPS_L3     = 3'h4,
        LPS_LDOWN  = 3'h5
    } lps_lstate_t;

    // ----------------------------------------
    // Link messages
    // ----------------------------------------
    typedef enum logic [2:0] {
        LPS_DN_NONE     = 3'h0,
        LPS_DN_SET_D    = 3'h1,
        LPS_DN_L1_EXIT  = 3'h2,
        LPS_DN_TURN_OFF = 3'h3,
        LPS_DN_TRAIN    = 3'h4
    } lps_dn_cmd_t;

    typedef enum logic [2:0] {
        LPS_UP_NONE      = 3'h0,
        LPS_UP_ACK       = 3'h1,
        LPS_UP_ENTER_L1  = 3'h2,
        LPS_UP_L1_EXIT   = 3'h3,
        LPS_UP_L23_READY = 3'h4,
        LPS_UP_PME       = 3'h5,
        LPS_UP_TRAIN_ACK = 3'h6
    } lps_up_cmd_t;

    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam int          LPS_TRAIN_CYCLES   = 16;
    localparam logic        LPS_ASPM_CTL_RST   = 1'b0;
    localparam logic        LPS_ASPM_CAP_VALUE = 1'b0;
endpackage : lps_pkg

// file: include/lps_link_if.sv
// Interface joining root port and attached device
interface lps_link_if;
    import lps_pkg::*;
    logic        dn_valid;
    lps_dn_cmd_t dn_cmd;
    lps_dstate_t dn_dstate;
    logic        up_valid;
    lps_up_cmd_t up_cmd;

    modport root (output dn_valid, output dn_cmd, output dn_dstate,
                  input up_valid, input up_cmd);
    modport dev  (input dn_valid, input dn_cmd, input dn_dstate,
                  output up_valid, output up_cmd);
endinterface : lps_link_if

// file: rtl/lps_train_timer.sv
// Link training timer used after reset and power restore
module lps_train_timer
    import lps_pkg::*;
#(
    parameter int CYCLES = LPS_TRAIN_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    input  wire logic i_start,
    output logic      o_done
);
    localparam int CW = $clog2(CYCLES + 1);

    generate
        if (CYCLES < 1) begin : g_bad
            $error("CYCLES must be at least 1");
        end
    endgenerate

    logic [CW-1:0] cnt_reg;

    // ----------------------------------------
    // Count down from start to done
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
        end else if (i_start) begin
            cnt_reg <= CW'(CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_done <= 1'b0;
        end else begin
            o_done <= !i_start && (cnt_reg == CW'(1) || (cnt_reg == '0 && o_done));
        end
    end
endmodule : lps_train_timer

// file: rtl/lps_root_port.sv
// Root port end: link power state inferred from device power state
module lps_root_port
    import lps_pkg::*;
#(
    parameter int TRAIN_CYCLES = LPS_TRAIN_CYCLES
) (
    input  wire logic  i_sys_clk,
    input  wire logic  i_rstn,
    lps_link_if.root   link,
    input  wire logic  i_pm_req,
    input  lps_dstate_t i_pm_dstate,
    input  wire logic  i_aspm_wr,
    input  wire logic  i_aspm_val,
    input  wire logic  i_main_pwr_off,
    input  wire logic  i_aux_present,
    input  wire logic  i_pwr_restore,
    output lps_lstate_t o_link_state,
    output lps_dstate_t o_dstate,
    output logic       o_busy,
    output logic       o_pme,
    output logic       o_pwr_off_ok,
    output logic       o_aspm_cap,
    output logic       o_aspm_ctl,
    output logic       o_ref_clk_gate,
    output logic       o_wake_tone
);
    typedef enum logic [3:0] {
        ST_TRAIN    = 4'h0,
        ST_L0       = 4'h1,
        ST_WAIT_ACK = 4'h3,
        ST_L1       = 4'h2,
        ST_SEND_D0  = 4'h6,
        ST_TURN_OFF = 4'h7,
        ST_L23RDY   = 4'h5,
        ST_L2       = 4'h4,
        ST_L3       = 4'hc
    } lps_root_st_t;

    lps_root_st_t state_reg;
    lps_root_st_t state_next;
    logic         cold_pend_reg;
    logic         train_start_reg;
    logic         train_ack_reg;
    logic         train_done;
    logic         up_hit;
    lps_up_cmd_t  up_cmd;

    assign up_hit = link.up_valid;
    assign up_cmd = link.up_cmd;

    lps_train_timer #(
        .CYCLES (TRAIN_CYCLES)
    ) u_train (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_start   (train_start_reg),
        .o_done    (train_done)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_TRAIN: begin
                if (train_done && train_ack_reg) begin
                    state_next = ST_L0;
                end
            end
            ST_L0: begin
                if (up_hit && up_cmd == LPS_UP_ENTER_L1) begin
                    state_next = ST_L1;
                end else if (i_pm_req) begin
                    state_next = ST_WAIT_ACK;
                end
            end
            ST_WAIT_ACK: begin
                if (up_hit && up_cmd == LPS_UP_ACK) begin
                    state_next = ST_L0;
                end else if (up_hit && up_cmd == LPS_UP_ENTER_L1) begin
                    state_next = cold_pend_reg ? ST_TURN_OFF : ST_L1;
                end
            end
            ST_L1: begin
                if (up_hit && up_cmd == LPS_UP_L1_EXIT) begin
                    state_next = ST_L0;
                end else if (i_pm_req && i_pm_dstate == LPS_D0) begin
                    state_next = ST_SEND_D0;
                end else if (i_pm_req && i_pm_dstate == LPS_D3COLD
                             && o_dstate == LPS_D3HOT) begin
                    state_next = ST_TURN_OFF;
                end
            end
            ST_SEND_D0: begin
                state_next = ST_WAIT_ACK;
            end
            ST_TURN_OFF: begin
                if (up_hit && up_cmd == LPS_UP_L23_READY) begin
                    state_next = ST_L23RDY;
                end
            end
            ST_L23RDY: begin
                if (i_main_pwr_off) begin
                    state_next = i_aux_present ? ST_L2 : ST_L3;
                end
            end
            ST_L2, ST_L3: begin
                if (i_pwr_restore) begin
                    state_next = ST_TRAIN;
                end
            end
            default: begin
                state_next = ST_TRAIN;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_TRAIN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Training handshake
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            train_start_reg <= 1'b1;
        end else begin
            train_start_reg <= state_next == ST_TRAIN && state_reg != ST_TRAIN;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            train_ack_reg <= 1'b0;
        end else if (up_hit && up_cmd == LPS_UP_TRAIN_ACK) begin
            train_ack_reg <= 1'b1;
        end else if (state_reg != ST_TRAIN) begin
            train_ack_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Device state and cold request
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_dstate      <= LPS_D0;
            cold_pend_reg <= 1'b0;
        end else if (state_next == ST_TRAIN) begin
            o_dstate      <= LPS_D0;
            cold_pend_reg <= 1'b0;
        end else if (state_reg == ST_L0 && state_next == ST_WAIT_ACK) begin
            o_dstate      <= (i_pm_dstate == LPS_D3COLD) ? LPS_D3HOT : i_pm_dstate;
            cold_pend_reg <= i_pm_dstate == LPS_D3COLD;
        end else if (state_reg == ST_SEND_D0) begin
            o_dstate <= LPS_D0;
        end else if (state_next == ST_L23RDY) begin
            o_dstate      <= LPS_D3COLD;
            cold_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Downstream messages
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            link.dn_valid  <= 1'b0;
            link.dn_cmd    <= LPS_DN_NONE;
            link.dn_dstate <= LPS_D0;
        end else begin
            link.dn_valid  <= 1'b0;
            link.dn_cmd    <= LPS_DN_NONE;
            link.dn_dstate <= LPS_D0;
            if (train_start_reg && state_reg == ST_TRAIN) begin
                link.dn_valid <= 1'b1;
                link.dn_cmd   <= LPS_DN_TRAIN;
            end else if (state_reg == ST_L0 && state_next == ST_WAIT_ACK) begin
                link.dn_valid  <= 1'b1;
                link.dn_cmd    <= LPS_DN_SET_D;
                link.dn_dstate <= (i_pm_dstate == LPS_D3COLD) ? LPS_D3HOT : i_pm_dstate;
            end else if (state_reg == ST_L1 && state_next == ST_SEND_D0) begin
                link.dn_valid <= 1'b1;
                link.dn_cmd   <= LPS_DN_L1_EXIT;
            end else if (state_reg == ST_SEND_D0) begin
                link.dn_valid  <= 1'b1;
                link.dn_cmd    <= LPS_DN_SET_D;
                link.dn_dstate <= LPS_D0;
            end else if (state_next == ST_TURN_OFF && state_reg != ST_TURN_OFF) begin
                link.dn_valid <= 1'b1;
                link.dn_cmd   <= LPS_DN_TURN_OFF;
            end
        end
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_link_state <= LPS_LDOWN;
            o_busy       <= 1'b1;
            o_pwr_off_ok <= 1'b0;
        end else begin
            unique case (state_next)
                ST_L0, ST_WAIT_ACK, ST_SEND_D0, ST_TURN_OFF: o_link_state <= LPS_L0;
                ST_L1:     o_link_state <= LPS_L1;
                ST_L23RDY: o_link_state <= LPS_L23RDY;
                ST_L2:     o_link_state <= LPS_L2;
                ST_L3:     o_link_state <= LPS_L3;
                default:   o_link_state <= LPS_LDOWN;
            endcase
            o_busy       <= !(state_next == ST_L0 || state_next == ST_L1);
            o_pwr_off_ok <= state_next == ST_L23RDY;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pme <= 1'b0;
        end else begin
            o_pme <= up_hit && up_cmd == LPS_UP_PME;
        end
    end

    // ----------------------------------------
    // ASPM capability and control
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_aspm_cap <= LPS_ASPM_CAP_VALUE;
        end else begin
            o_aspm_cap <= LPS_ASPM_CAP_VALUE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_aspm_ctl <= LPS_ASPM_CTL_RST;
        end else if (i_aspm_wr) begin
            o_aspm_ctl <= i_aspm_val;
        end
    end

    // ----------------------------------------
    // No per-port clock gating or wake tone
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ref_clk_gate <= 1'b0;
            o_wake_tone    <= 1'b0;
        end else begin
            o_ref_clk_gate <= 1'b0;
            o_wake_tone    <= 1'b0;
        end
    end
endmodule : lps_root_port

// file: rtl/lps_endpoint.sv
// Attached device end: follows set device-state messages from the port
module lps_endpoint
    import lps_pkg::*;
#(
    parameter bit SUP_D1 = 1'b1,
    parameter bit SUP_D2 = 1'b1
) (
    input  wire logic  i_sys_clk,
    input  wire logic  i_rstn,
    lps_link_if.dev    link,
    input  wire logic  i_pme_en,
    input  wire logic  i_pme_req,
    input  wire logic  i_tx_req,
    input  wire logic  i_init_done,
    output lps_dstate_t o_dstate,
    output lps_lstate_t o_link_view,
    output logic       o_tx_grant,
    output logic       o_ctx_valid,
    output logic       o_bad_dstate
);
    logic        pme_pend_reg;
    logic        dn_hit;
    lps_dstate_t dn_d;
    logic        d_ok;
    logic        low_d;

    assign dn_hit = link.dn_valid;
    assign dn_d   = link.dn_dstate;
    assign d_ok   = !((dn_d == LPS_D1 && !SUP_D1) || (dn_d == LPS_D2 && !SUP_D2));
    assign low_d  = o_dstate != LPS_D0;

    // ----------------------------------------
    // Device state and link view
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_dstate    <= LPS_D0;
            o_link_view <= LPS_LDOWN;
        end else if (dn_hit && link.dn_cmd == LPS_DN_TRAIN) begin
            o_dstate    <= LPS_D0;
            o_link_view <= LPS_L0;
        end else if (dn_hit && link.dn_cmd == LPS_DN_SET_D && d_ok) begin
            o_dstate    <= dn_d;
            o_link_view <= (dn_d == LPS_D0) ? LPS_L0 : LPS_L1;
        end else if (dn_hit && link.dn_cmd == LPS_DN_L1_EXIT) begin
            o_link_view <= LPS_L0;
        end else if (dn_hit && link.dn_cmd == LPS_DN_TURN_OFF) begin
            o_dstate    <= LPS_D3COLD;
            o_link_view <= LPS_L23RDY;
        end else if (!dn_hit && o_link_view == LPS_L1 && pme_pend_reg) begin
            o_link_view <= LPS_L0;
        end else if (!dn_hit && o_link_view == LPS_L0 && low_d && !pme_pend_reg) begin
            o_link_view <= LPS_L1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bad_dstate <= 1'b0;
        end else begin
            o_bad_dstate <= dn_hit && link.dn_cmd == LPS_DN_SET_D && !d_ok;
        end
    end

    // ----------------------------------------
    // Functional context
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ctx_valid <= 1'b0;
        end else if (dn_hit && (link.dn_cmd == LPS_DN_TRAIN || link.dn_cmd == LPS_DN_TURN_OFF
                     || (link.dn_cmd == LPS_DN_SET_D && dn_d >= LPS_D3HOT))) begin
            o_ctx_valid <= 1'b0;
        end else if (i_init_done) begin
            o_ctx_valid <= 1'b1;
        end
    end

    // ----------------------------------------
    // Pending power event, set wins over send
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pme_pend_reg <= 1'b0;
        end else if (i_pme_req && i_pme_en) begin
            pme_pend_reg <= 1'b1;
        end else if (!dn_hit && o_link_view == LPS_L0 && pme_pend_reg) begin
            pme_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Upstream messages
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            link.up_valid <= 1'b0;
            link.up_cmd   <= LPS_UP_NONE;
        end else begin
            link.up_valid <= 1'b1;
            link.up_cmd   <= LPS_UP_NONE;
            if (dn_hit) begin
                unique case (link.dn_cmd)
                    LPS_DN_TRAIN:    link.up_cmd <= LPS_UP_TRAIN_ACK;
                    LPS_DN_TURN_OFF: link.up_cmd <= LPS_UP_L23_READY;
                    LPS_DN_SET_D: begin
                        link.up_cmd <= (d_ok && dn_d != LPS_D0) ? LPS_UP_ENTER_L1
                                                                : LPS_UP_ACK;
                    end
                    default: link.up_valid <= 1'b0;
                endcase
            end else if (o_link_view == LPS_L1 && pme_pend_reg) begin
                link.up_cmd <= LPS_UP_L1_EXIT;
            end else if (o_link_view == LPS_L0 && pme_pend_reg) begin
                link.up_cmd <= LPS_UP_PME;
            end else if (o_link_view == LPS_L0 && low_d) begin
                link.up_cmd <= LPS_UP_ENTER_L1;
            end else begin
                link.up_valid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Master traffic only in D0 on active link
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_grant <= 1'b0;
        end else begin
            o_tx_grant <= i_tx_req && !low_d && o_link_view == LPS_L0 && o_ctx_valid;
        end
    end
endmodule : lps_endpoint

// file: sim/lps_link_props.sv
// Checker for messages crossing the root port link
module lps_link_props
    import lps_pkg::*;
(
    input wire logic   i_sys_clk,
    input wire logic   i_rstn,
    input wire logic   dn_valid,
    input lps_dn_cmd_t dn_cmd,
    input lps_dstate_t dn_dstate,
    input wire logic   up_valid,
    input lps_up_cmd_t up_cmd
);
    // ----------------------------------------
    // Link message properties
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    property p_train_first;
        $rose(i_rstn) |-> ##[0:2] (dn_valid && dn_cmd == LPS_DN_TRAIN);
    endproperty
    a_train_first: assert property (p_train_first)
        else $error("no training after reset");

    property p_train_ack;
        dn_valid && dn_cmd == LPS_DN_TRAIN |=> up_valid && up_cmd == LPS_UP_TRAIN_ACK;
    endproperty
    a_train_ack: assert property (p_train_ack)
        else $error("training not acknowledged");

    property p_train_quiet;
        dn_valid && dn_cmd == LPS_DN_TRAIN |=> !dn_valid [*2];
    endproperty
    a_train_quiet: assert property (p_train_quiet)
        else $error("message during training");

    property p_low_l1;
        dn_valid && dn_cmd == LPS_DN_SET_D && dn_dstate inside {LPS_D1, LPS_D2, LPS_D3HOT}
            |=> up_valid && up_cmd == LPS_UP_ENTER_L1;
    endproperty
    a_low_l1: assert property (p_low_l1)
        else $error("low state did not enter L1");

    property p_d0_ack;
        dn_valid && dn_cmd == LPS_DN_SET_D && dn_dstate == LPS_D0
            |=> up_valid && up_cmd == LPS_UP_ACK;
    endproperty
    a_d0_ack: assert property (p_d0_ack)
        else $error("return to D0 not acknowledged");

    property p_turn_off;
        dn_valid && dn_cmd == LPS_DN_TURN_OFF |=> up_valid && up_cmd == LPS_UP_L23_READY;
    endproperty
    a_turn_off: assert property (p_turn_off)
        else $error("turn off without ready reply");

    property p_pme;
        up_valid && up_cmd == LPS_UP_L1_EXIT |-> ##[1:3] (up_valid && up_cmd == LPS_UP_PME);
    endproperty
    a_pme: assert property (p_pme)
        else $error("device exit without event message");

    property p_set_d_legal;
        dn_valid && dn_cmd == LPS_DN_SET_D
            |-> dn_dstate inside {LPS_D0, LPS_D1, LPS_D2, LPS_D3HOT};
    endproperty
    a_set_d_legal: assert property (p_set_d_legal)
        else $error("illegal device state sent");
endmodule : lps_link_props

// file: sim/pcie_root_port_link_power_states_tb.sv
// Testbench joining root port and attached device
module pcie_root_port_link_power_states_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lps_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        clk = 1'b0, rstn = 1'b0, pm_req = 1'b0, aspm_wr = 1'b0, aspm_val = 1'b0;
    logic        main_off = 1'b0, aux = 1'b0, restore = 1'b0, pme_en = 1'b0;
    logic        pme_req = 1'b0, tx_req = 1'b0, init_done = 1'b0, gs = 1'b0, ps = 1'b0;
    lps_dstate_t pm_d = LPS_D0;
    lps_dstate_t r_d, e_d;
    lps_lstate_t ls, view;
    logic        busy, pme, off_ok, cap, ctl, gate, tone, grant, ctx;
    int          errors = 0;
    int          check_count = 0;

    lps_link_if link_inst ();
    lps_root_port #(.TRAIN_CYCLES(2)) lps_root_port_inst (
        .i_sys_clk(clk), .i_rstn(rstn), .link(link_inst.root), .i_pm_req(pm_req),
        .i_pm_dstate(pm_d), .i_aspm_wr(aspm_wr), .i_aspm_val(aspm_val),
        .i_main_pwr_off(main_off), .i_aux_present(aux), .i_pwr_restore(restore),
        .o_link_state(ls), .o_dstate(r_d), .o_busy(busy), .o_pme(pme),
        .o_pwr_off_ok(off_ok), .o_aspm_cap(cap), .o_aspm_ctl(ctl),
        .o_ref_clk_gate(gate), .o_wake_tone(tone));
    lps_endpoint lps_endpoint_inst (
        .i_sys_clk(clk), .i_rstn(rstn), .link(link_inst.dev), .i_pme_en(pme_en),
        .i_pme_req(pme_req), .i_tx_req(tx_req), .i_init_done(init_done),
        .o_dstate(e_d), .o_link_view(view), .o_tx_grant(grant), .o_ctx_valid(ctx),
        .o_bad_dstate());
    lps_link_props lps_link_props_inst (
        .i_sys_clk(clk), .i_rstn(rstn), .dn_valid(link_inst.dn_valid),
        .dn_cmd(link_inst.dn_cmd), .dn_dstate(link_inst.dn_dstate),
        .up_valid(link_inst.up_valid), .up_cmd(link_inst.up_cmd));

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (grant === 1'b1) gs = 1'b1;
        if (pme === 1'b1) ps = 1'b1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic step(int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic chk(logic [2:0] got, logic [2:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(bit deep);
        int k;
        k = 0;
        step(2);
        while ((deep ? off_ok !== 1'b1 : busy !== 1'b0) && k < 300) begin
            step(1);
            k++;
        end
        if (k == 300) errors++;
    endtask : idle

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(3);
    endtask : pulse

    task automatic req(lps_dstate_t d);
        pm_d = d;
        pulse(pm_req);
        idle(1'b0);
    endtask : req

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #100us;
        errors++;
        print_verdict();
    end

    initial begin
        step(3);
        rstn = 1'b1;
        idle(1'b0);
        chk(ls, LPS_L0);
        chk(view, LPS_L0);
        chk({2'h0, cap}, 3'h0);
        chk({2'h0, ctl}, 3'h0);
        chk({1'b0, gate, tone}, 3'h0);
        aspm_val = 1'b1;
        pulse(aspm_wr);
        chk({2'h0, ctl}, 3'h1);
        step(20);
        chk(ls, LPS_L0);
        aspm_val = 1'b0;
        pulse(aspm_wr);
        chk({2'h0, ctl}, 3'h0);
        pulse(init_done);
        pulse(tx_req);
        chk({2'h0, gs}, 3'h1);
        for (int i = 1; i < 4; i++) begin
            req(lps_dstate_t'(i));
            chk(ls, LPS_L1);
            chk(e_d, 3'(i));
            chk({2'h0, ctx}, {2'h0, i < 3});
            gs = 1'b0;
            pulse(tx_req);
            chk({2'h0, gs}, 3'h0);
            req(LPS_D0);
            chk(ls, LPS_L0);
            chk(e_d, LPS_D0);
            chk({2'h0, ctx}, {2'h0, i < 3});
            pulse(init_done);
        end
        req(LPS_D1);
        req(LPS_D2);
        chk(ls, LPS_L1);
        chk(r_d, LPS_D1);
        pme_en = 1'b1;
        ps = 1'b0;
        pulse(pme_req);
        step(8);
        chk({2'h0, ps}, 3'h1);
        chk(ls, LPS_L1);
        pme_en = 1'b0;
        req(LPS_D0);
        for (int a = 1; a >= 0; a--) begin
            aux = a[0];
            pm_d = LPS_D3COLD;
            pulse(pm_req);
            idle(1'b1);
            chk(ls, LPS_L23RDY);
            chk(r_d, LPS_D3COLD);
            main_off = 1'b1;
            step(2);
            chk(ls, a != 0 ? LPS_L2 : LPS_L3);
            main_off = 1'b0;
            restore = 1'b1;
            step(1);
            restore = 1'b0;
            idle(1'b0);
            chk(ls, LPS_L0);
            chk(r_d, LPS_D0);
            chk({2'h0, ctx}, 3'h0);
            pulse(init_done);
        end
        print_verdict();
    end
endmodule : pcie_root_port_link_power_states_tb
